// File: src/pocr_consts.svh
// Register offsets, reset values, writable-bit masks and scale constants of the output control bank
`ifndef POCR_CONSTS_SVH
`define POCR_CONSTS_SVH
`define POCR_ADDR_LED_SINK_ENABLE 8'h6B
`define POCR_ADDR_ONOFF 8'h70
`define POCR_ADDR_CONV3_V 8'h72
`define POCR_ADDR_CONV4_V 8'h73
`define POCR_ADDR_SINK12_I 8'h75
`define POCR_ADDR_SINK3_I 8'h76
`define POCR_ADDR_SLEW 8'h77
`define POCR_ADDR_CONV_DIS 8'h78
`define POCR_ADDR_LIN18_DIS 8'h79
`define POCR_ADDR_LIN9_DIS 8'h7A
`define POCR_RST_LED_SINK_ENABLE 8'h00
`define POCR_RST_ONOFF 8'h03
`define POCR_RST_CONV3_V 8'h06
`define POCR_RST_CONV4_V 8'h08
`define POCR_RST_SINK12_I 8'h3F
`define POCR_RST_SINK3_I 8'h07
`define POCR_RST_SLEW 8'h02
`define POCR_RST_CONV_DIS 8'h04
`define POCR_RST_LIN18_DIS 8'h00
`define POCR_RST_LIN9_DIS 8'h00
`define POCR_MASK_LED_SINK_ENABLE 8'h07
`define POCR_MASK_ONOFF 8'h1F
`define POCR_MASK_VOLT 8'h0F
`define POCR_MASK_SINK12_I 8'h3F
`define POCR_MASK_SINK3_I 8'h07
`define POCR_MASK_SLEW 8'h03
`define POCR_MASK_CONV_DIS 8'h0F
`define POCR_MASK_LIN18_DIS 8'hFF
`define POCR_MASK_LIN9_DIS 8'h01
`define POCR_CONV3_MV_BASE 2900
`define POCR_CONV4_MV_BASE 3000
`define POCR_VOLT_STEP_MV 50
`define POCR_SINK_STEP_UA 3000
`endif

// File: src/pocr_pkg.sv
// Types shared by the output control register bank
package pocr_pkg;
	typedef enum logic [1:0] {POCR_CTRL_OFF, POCR_CTRL_ON, POCR_CTRL_PIN} pocr_ctrl_e;
	typedef struct packed {
		logic [2:0] sink_on;
		logic [2:0] sink1_current_code;
		logic [2:0] sink2_current_code;
		logic [2:0] sink3_current_code;
	} pocr_sink_s;
	typedef struct packed {
		pocr_ctrl_e conv3_ctrl;
		pocr_ctrl_e conv4_ctrl;
		logic [11:0] conv3_mv;
		logic [11:0] conv4_mv;
		logic [1:0] conv1_slope_code;
		logic [3:0] conv_discharge_en;
		logic [8:0] linreg_discharge_en;
		logic slow_clock_on;
	} pocr_power_s;
	typedef struct packed {
		logic [7:0] led_sink_enable;
		logic [7:0] onoff;
		logic [7:0] conv3_v;
		logic [7:0] conv4_v;
		logic [7:0] sink12_i;
		logic [7:0] sink3_i;
		logic [7:0] slew;
		logic [7:0] conv_dis;
		logic [7:0] lin18_dis;
		logic [7:0] lin9_dis;
	} pocr_bank_s;
endpackage : pocr_pkg

// File: src/pocr_enable_decode.sv
// Decoder for a two-bit converter enable field
`timescale 1ns/1ps
`default_nettype none
module pocr_enable_decode
	import pocr_pkg::*;
(
	input wire logic [1:0] i_field,
	input wire logic i_present,
	output pocr_ctrl_e o_ctrl
);
	always_comb
	begin
		if (!i_present)
			o_ctrl = POCR_CTRL_OFF;
		else if (i_field[1])
			o_ctrl = POCR_CTRL_PIN;
		else if (i_field[0])
			o_ctrl = POCR_CTRL_ON;
		else
			o_ctrl = POCR_CTRL_OFF;
	end
endmodule : pocr_enable_decode
`default_nettype wire

// File: src/pocr_voltage_map.sv
// Linear map from a four-bit converter code to millivolts
`timescale 1ns/1ps
`default_nettype none
module pocr_voltage_map #(
	parameter logic [11:0] BASE_MV = 12'd2900,
	parameter logic [11:0] STEP_MV = 12'd50
) (
	input wire logic [3:0] i_code,
	input wire logic i_present,
	output logic [11:0] o_mv
);
	logic [11:0] scaled;
	always_comb
	begin
		scaled = 12'({8'h00, i_code} * STEP_MV);
		o_mv = i_present ? 12'(BASE_MV + scaled) : 12'h000;
	end
endmodule : pocr_voltage_map
`default_nettype wire

// File: src/pocr_bank.sv
// Output control register bank: sinks, converters 3/4, slow clock, discharge
//
// Notes on behaviour
// - Sink enable register holds enables for sinks 3,2,1 at bits 2,1,0; reset zero.
// - Converter 3 field: 00 off, 01 on by register, 1x hands control to pin.
// - On/off bit 0 runs the slow clock when set; register resets to 03.
// - Converter 3 code: 2.90V plus 50mV per step; reset code 06.
// - Converter 4 code: 3.00V plus 50mV per step; reset code 08.
// - Sink 1 code bits 5:3, sink 2 bits 2:0; (code+1)*3mA; reset 3F.
// - Sink 3 code bits 2:0 with the same current steps; reset 07.
// - Converter 1 slope code selects 5, 10, 12.5 or 25 mV/us; reset 02.
// - Converter discharge register: one enable per converter; reset only converter 2.
// - Linear regulators 1 to 8 discharge at bits 7 down to 0; reset zero.
// - Linear regulator 9 discharge at bit 0; bits 7:1 reserved; reset zero.
// - Reduced variant: converter 3/4 fields and their discharge bits (register bits 1:0) have no effect.
`timescale 1ns/1ps
`default_nettype none
`include "pocr_consts.svh"
module pocr_bank
	import pocr_pkg::*;
#(
	parameter bit HAS_CONV34 = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_rd_hit,
	output pocr_sink_s o_sink,
	output pocr_power_s o_power,
	output logic [4:0] o_sink1_ma,
	output logic [4:0] o_sink2_ma,
	output logic [4:0] o_sink3_ma,
	output logic [7:0] o_slew_tenth_mv_us
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		pocr_bank_s bank;
		logic [7:0] rdata;
		logic rd_hit;
		pocr_sink_s sink;
		pocr_power_s power;
		logic [4:0] sink1_ma;
		logic [4:0] sink2_ma;
		logic [4:0] sink3_ma;
		logic [7:0] slew;
	} pocr_state_s;

	pocr_state_s state_reg;
	pocr_state_s state_next;
	pocr_ctrl_e conv3_ctrl;
	pocr_ctrl_e conv4_ctrl;
	logic [11:0] conv3_mv;
	logic [11:0] conv4_mv;

	// ****************************************
	// Field decoders
	// ****************************************
	pocr_enable_decode u_conv3_en (
		.i_field(state_next.bank.onoff[2:1]),
		.i_present(HAS_CONV34),
		.o_ctrl(conv3_ctrl)
	);
	pocr_enable_decode u_conv4_en (
		.i_field(state_next.bank.onoff[4:3]),
		.i_present(HAS_CONV34),
		.o_ctrl(conv4_ctrl)
	);
	pocr_voltage_map #(
		.BASE_MV(12'(`POCR_CONV3_MV_BASE)),
		.STEP_MV(12'(`POCR_VOLT_STEP_MV))
	) u_conv3_v (
		.i_code(state_next.bank.conv3_v[3:0]),
		.i_present(HAS_CONV34),
		.o_mv(conv3_mv)
	);
	pocr_voltage_map #(
		.BASE_MV(12'(`POCR_CONV4_MV_BASE)),
		.STEP_MV(12'(`POCR_VOLT_STEP_MV))
	) u_conv4_v (
		.i_code(state_next.bank.conv4_v[3:0]),
		.i_present(HAS_CONV34),
		.o_mv(conv4_mv)
	);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [4:0] sink_ma(input logic [2:0] code);
		logic [4:0] steps;
		steps = {2'b00, code} + 5'h01;
		sink_ma = 5'(steps * 5'h03);
	endfunction : sink_ma

	function automatic logic [7:0] slew_tenths(input logic [1:0] code);
		logic [7:0] val;
		val = 8'h00;
		unique case (code)
			2'b00: val = 8'h32;
			2'b01: val = 8'h64;
			2'b10: val = 8'h7D;
			2'b11: val = 8'hFA;
		endcase
		slew_tenths = val;
	endfunction : slew_tenths

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		state_next = state_reg;
		state_next.rd_hit = 1'b0;
		if (i_wr_en)
		begin
			// Reserved bits masked so they always read zero
			unique case (i_addr)
				`POCR_ADDR_LED_SINK_ENABLE: state_next.bank.led_sink_enable = i_wdata & `POCR_MASK_LED_SINK_ENABLE;
				`POCR_ADDR_ONOFF: state_next.bank.onoff = i_wdata & `POCR_MASK_ONOFF;
				`POCR_ADDR_CONV3_V: state_next.bank.conv3_v = i_wdata & `POCR_MASK_VOLT;
				`POCR_ADDR_CONV4_V: state_next.bank.conv4_v = i_wdata & `POCR_MASK_VOLT;
				`POCR_ADDR_SINK12_I: state_next.bank.sink12_i = i_wdata & `POCR_MASK_SINK12_I;
				`POCR_ADDR_SINK3_I: state_next.bank.sink3_i = i_wdata & `POCR_MASK_SINK3_I;
				`POCR_ADDR_SLEW: state_next.bank.slew = i_wdata & `POCR_MASK_SLEW;
				`POCR_ADDR_CONV_DIS: state_next.bank.conv_dis = i_wdata & `POCR_MASK_CONV_DIS;
				`POCR_ADDR_LIN18_DIS: state_next.bank.lin18_dis = i_wdata & `POCR_MASK_LIN18_DIS;
				`POCR_ADDR_LIN9_DIS: state_next.bank.lin9_dis = i_wdata & `POCR_MASK_LIN9_DIS;
				default: ;
			endcase
		end
		if (i_rd_en)
		begin
			state_next.rd_hit = 1'b1;
			unique case (i_addr)
				`POCR_ADDR_LED_SINK_ENABLE: state_next.rdata = state_reg.bank.led_sink_enable;
				`POCR_ADDR_ONOFF: state_next.rdata = state_reg.bank.onoff;
				`POCR_ADDR_CONV3_V: state_next.rdata = state_reg.bank.conv3_v;
				`POCR_ADDR_CONV4_V: state_next.rdata = state_reg.bank.conv4_v;
				`POCR_ADDR_SINK12_I: state_next.rdata = state_reg.bank.sink12_i;
				`POCR_ADDR_SINK3_I: state_next.rdata = state_reg.bank.sink3_i;
				`POCR_ADDR_SLEW: state_next.rdata = state_reg.bank.slew;
				`POCR_ADDR_CONV_DIS: state_next.rdata = state_reg.bank.conv_dis;
				`POCR_ADDR_LIN18_DIS: state_next.rdata = state_reg.bank.lin18_dis;
				`POCR_ADDR_LIN9_DIS: state_next.rdata = state_reg.bank.lin9_dis;
				default:
				begin
					state_next.rdata = 8'h00;
					state_next.rd_hit = 1'b0;
				end
			endcase
		end

		// Reset ahead of decode so decoded outputs carry reset values too
		if (i_srst)
		begin
			state_next = '0;
			state_next.bank.led_sink_enable = `POCR_RST_LED_SINK_ENABLE;
			state_next.bank.onoff = `POCR_RST_ONOFF;
			state_next.bank.conv3_v = `POCR_RST_CONV3_V;
			state_next.bank.conv4_v = `POCR_RST_CONV4_V;
			state_next.bank.sink12_i = `POCR_RST_SINK12_I;
			state_next.bank.sink3_i = `POCR_RST_SINK3_I;
			state_next.bank.slew = `POCR_RST_SLEW;
			state_next.bank.conv_dis = `POCR_RST_CONV_DIS;
			state_next.bank.lin18_dis = `POCR_RST_LIN18_DIS;
			state_next.bank.lin9_dis = `POCR_RST_LIN9_DIS;
		end

		// Decoded controls follow the bank one cycle after a write
		state_next.sink.sink_on = state_next.bank.led_sink_enable[2:0];
		state_next.sink.sink1_current_code = state_next.bank.sink12_i[5:3];
		state_next.sink.sink2_current_code = state_next.bank.sink12_i[2:0];
		state_next.sink.sink3_current_code = state_next.bank.sink3_i[2:0];
		state_next.sink1_ma = sink_ma(state_next.bank.sink12_i[5:3]);
		state_next.sink2_ma = sink_ma(state_next.bank.sink12_i[2:0]);
		state_next.sink3_ma = sink_ma(state_next.bank.sink3_i[2:0]);
		state_next.power.slow_clock_on = state_next.bank.onoff[0];
		state_next.power.conv3_ctrl = conv3_ctrl;
		state_next.power.conv4_ctrl = conv4_ctrl;
		state_next.power.conv3_mv = conv3_mv;
		state_next.power.conv4_mv = conv4_mv;
		state_next.power.conv1_slope_code = state_next.bank.slew[1:0];
		state_next.slew = slew_tenths(state_next.bank.slew[1:0]);
		state_next.power.conv_discharge_en = {state_next.bank.conv_dis[0] & HAS_CONV34,
			state_next.bank.conv_dis[1] & HAS_CONV34, state_next.bank.conv_dis[2], state_next.bank.conv_dis[3]};
		state_next.power.linreg_discharge_en = {state_next.bank.lin9_dis[0],
			state_next.bank.lin18_dis[0], state_next.bank.lin18_dis[1], state_next.bank.lin18_dis[2],
			state_next.bank.lin18_dis[3], state_next.bank.lin18_dis[4], state_next.bank.lin18_dis[5],
			state_next.bank.lin18_dis[6], state_next.bank.lin18_dis[7]};
	end

	// ****************************************
	// Registers and outputs
	// ****************************************
	always_ff @(posedge i_clk)
	begin
		state_reg <= state_next;
	end

	assign o_rdata = state_reg.rdata;
	assign o_rd_hit = state_reg.rd_hit;
	assign o_sink = state_reg.sink;
	assign o_power = state_reg.power;
	assign o_sink1_ma = state_reg.sink1_ma;
	assign o_sink2_ma = state_reg.sink2_ma;
	assign o_sink3_ma = state_reg.sink3_ma;
	assign o_slew_tenth_mv_us = state_reg.slew;
endmodule : pocr_bank
`default_nettype wire

// File: verification/pocr_monitor.sv
// Port checker for the output control register bank
`timescale 1ns/1ps
`default_nettype none
`include "pocr_consts.svh"
module pocr_monitor
	import pocr_pkg::*;
#(
	parameter bit HAS_CONV34 = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] o_rdata,
	input wire logic o_rd_hit,
	input wire pocr_sink_s o_sink,
	input wire pocr_power_s o_power,
	input wire logic [4:0] o_sink1_ma,
	input wire logic [4:0] o_sink2_ma,
	input wire logic [4:0] o_sink3_ma,
	input wire logic [7:0] o_slew_tenth_mv_us
);
	logic [7:0] wd_q;
	logic mapped;
	assign mapped = i_addr inside {`POCR_ADDR_LED_SINK_ENABLE, `POCR_ADDR_ONOFF, `POCR_ADDR_CONV3_V, `POCR_ADDR_CONV4_V,
		`POCR_ADDR_SINK12_I, `POCR_ADDR_SINK3_I, `POCR_ADDR_SLEW, `POCR_ADDR_CONV_DIS, `POCR_ADDR_LIN18_DIS,
		`POCR_ADDR_LIN9_DIS};
	always_ff @(posedge i_clk) wd_q <= i_wdata;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// ****************
	// Properties
	// ****************
	property p_led; i_wr_en && i_addr == `POCR_ADDR_LED_SINK_ENABLE |=> o_sink.sink_on == wd_q[2:0]; endproperty
	property p_clk; i_wr_en && i_addr == `POCR_ADDR_ONOFF |=> o_power.slow_clock_on == wd_q[0]; endproperty
	property p_m3; HAS_CONV34 && i_wr_en && i_addr == `POCR_ADDR_ONOFF |=> o_power.conv3_ctrl ==
		(wd_q[2:1] == 2'h0 ? POCR_CTRL_OFF : wd_q[2:1] == 2'h1 ? POCR_CTRL_ON : POCR_CTRL_PIN); endproperty
	property p_m4; HAS_CONV34 && i_wr_en && i_addr == `POCR_ADDR_ONOFF |=> o_power.conv4_ctrl ==
		(wd_q[4:3] == 2'h0 ? POCR_CTRL_OFF : wd_q[4:3] == 2'h1 ? POCR_CTRL_ON : POCR_CTRL_PIN); endproperty
	property p_v3; HAS_CONV34 && i_wr_en && i_addr == `POCR_ADDR_CONV3_V |=>
		o_power.conv3_mv == 12'(2900 + 50 * wd_q[3:0]); endproperty
	property p_v4; HAS_CONV34 && i_wr_en && i_addr == `POCR_ADDR_CONV4_V |=>
		o_power.conv4_mv == 12'(3000 + 50 * wd_q[3:0]); endproperty
	property p_ma; o_sink1_ma == 5'(3 * (o_sink.sink1_current_code + 1)) &&
		o_sink2_ma == 5'(3 * (o_sink.sink2_current_code + 1)); endproperty
	property p_ma3; o_sink3_ma == 5'(3 * (o_sink.sink3_current_code + 1)); endproperty
	property p_slew; o_slew_tenth_mv_us == (o_power.conv1_slope_code == 2'h0 ? 8'h32 :
		o_power.conv1_slope_code == 2'h1 ? 8'h64 : o_power.conv1_slope_code == 2'h2 ? 8'h7D : 8'hFA); endproperty
	property p_dis; i_wr_en && i_addr == `POCR_ADDR_CONV_DIS |=> o_power.conv_discharge_en ==
		{wd_q[0] & HAS_CONV34, wd_q[1] & HAS_CONV34, wd_q[2], wd_q[3]}; endproperty
	property p_hit; i_rd_en && mapped |=> o_rd_hit; endproperty
	property p_idle; !i_rd_en |=> !o_rd_hit; endproperty
	property p_miss; i_rd_en && !mapped |=> !o_rd_hit && o_rdata == 8'h00; endproperty
	property p_rst; disable iff (1'b0) i_srst |=> o_power.slow_clock_on && o_sink.sink_on == 3'h0 &&
		o_sink1_ma == 5'h18 && o_slew_tenth_mv_us == 8'h7D && o_power.conv_discharge_en == 4'h2; endproperty
	a_led: assert property (p_led) else $error("sink enables differ from write");
	a_clk: assert property (p_clk) else $error("slow clock enable differs");
	a_m3: assert property (p_m3) else $error("converter 3 mode decode wrong");
	a_m4: assert property (p_m4) else $error("converter 4 mode decode wrong");
	a_v3: assert property (p_v3) else $error("converter 3 voltage wrong");
	a_v4: assert property (p_v4) else $error("converter 4 voltage wrong");
	a_ma: assert property (p_ma) else $error("sink 1 or 2 current wrong");
	a_ma3: assert property (p_ma3) else $error("sink 3 current wrong");
	a_slew: assert property (p_slew) else $error("slew rate wrong");
	a_dis: assert property (p_dis) else $error("converter discharge order wrong");
	a_hit: assert property (p_hit) else $error("read hit pulse wrong");
	a_idle: assert property (p_idle) else $error("read hit without read");
	a_miss: assert property (p_miss) else $error("unmapped read answered");
	a_rst: assert property (p_rst) else $error("reset values wrong");
	c_mode: cover property (i_wr_en && i_addr == `POCR_ADDR_ONOFF);
	c_hit: cover property (o_rd_hit);
	c_miss: cover property (i_rd_en && !mapped);
endmodule : pocr_monitor
`default_nettype wire

// File: verification/pocr_host.sv
// Host model issuing single-byte register writes and reads
`timescale 1ns/1ps
`default_nettype none
module pocr_host (
	input wire logic i_clk,
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	input wire logic [7:0] i_rdata,
	input wire logic i_rd_hit
);
	initial
	begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr_en <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr_en <= 1'b0;
		o_wdata <= ~d;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
		@(posedge i_clk);
		o_rd_en <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd_en <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
		h = i_rd_hit;
	endtask : rd
endmodule : pocr_host
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the output control register bank
`timescale 1ns/1ps
`default_nettype none
`include "pocr_consts.svh"
module testbench;
	import pocr_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic wr_en, rd_en, rd_hit;
	logic [7:0] addr, wdata, rdata, slew;
	logic [4:0] ma1, ma2, ma3;
	pocr_sink_s sink;
	pocr_power_s pwr;
	pocr_power_s pwr_r;
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	initial forever #4 clk = ~clk;
	pocr_bank #(.HAS_CONV34(1'b1)) dut (.i_clk(clk), .i_srst(srst), .i_wr_en(wr_en), .i_rd_en(rd_en),
		.i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rd_hit(rd_hit), .o_sink(sink), .o_power(pwr),
		.o_sink1_ma(ma1), .o_sink2_ma(ma2), .o_sink3_ma(ma3), .o_slew_tenth_mv_us(slew));
	pocr_bank #(.HAS_CONV34(1'b0)) dut_red (.i_clk(clk), .i_srst(srst), .i_wr_en(wr_en), .i_rd_en(rd_en),
		.i_addr(addr), .i_wdata(wdata), .o_rdata(), .o_rd_hit(), .o_sink(), .o_power(pwr_r),
		.o_sink1_ma(), .o_sink2_ma(), .o_sink3_ma(), .o_slew_tenth_mv_us());
	pocr_host host (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata),
		.i_rdata(rdata), .i_rd_hit(rd_hit));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic hx);
		logic [7:0] d;
		logic h;
		host.rd(a, d, h);
		chk("rdata", {8'h00, e}, {8'h00, d});
		chk("rd_hit", {15'h0, hx}, {15'h0, h});
	endtask : rdchk
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		logic [7:0] ra[10] = '{8'h6B, 8'h70, 8'h72, 8'h73, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7A};
		logic [7:0] rv[10] = '{8'h00, 8'h03, 8'h06, 8'h08, 8'h3F, 8'h07, 8'h02, 8'h04, 8'h00, 8'h00};
		for (int i = 0; i < 10; i++) rdchk(ra[i], rv[i], 1'b1);
		chk("conv3_ctrl", 16'(POCR_CTRL_ON), 16'(pwr.conv3_ctrl));
		chk("conv3_mv", 16'd3200, 16'(pwr.conv3_mv));
		chk("conv4_mv", 16'd3400, 16'(pwr.conv4_mv));
		chk("red_conv3_ctrl", 16'(POCR_CTRL_OFF), 16'(pwr_r.conv3_ctrl));
		chk("red_conv3_mv", 16'h0, 16'(pwr_r.conv3_mv));
		chk("clock", 16'h1, 16'(pwr.slow_clock_on));
		chk("conv_dis", 16'h2, 16'(pwr.conv_discharge_en));
		chk("sink3_ma", 16'd24, 16'(ma3));
		$display("reset values done");
	endtask : t_reset
	task automatic t_modes;
		for (int c = 0; c < 4; c++)
		begin
			host.wr(8'h70, {3'h0, 2'(c), 2'(c), 1'b0});
			chk("conv3_ctrl", 16'(c == 0 ? POCR_CTRL_OFF : c == 1 ? POCR_CTRL_ON : POCR_CTRL_PIN), 16'(pwr.conv3_ctrl));
			chk("conv4_ctrl", 16'(c == 0 ? POCR_CTRL_OFF : c == 1 ? POCR_CTRL_ON : POCR_CTRL_PIN), 16'(pwr.conv4_ctrl));
			chk("red_conv4_ctrl", 16'(POCR_CTRL_OFF), 16'(pwr_r.conv4_ctrl));
			chk("clock", 16'h0, 16'(pwr.slow_clock_on));
			rdchk(8'h70, {3'h0, 2'(c), 2'(c), 1'b0}, 1'b1);
		end
		host.wr(8'h6B, 8'h05);
		chk("sink_on", 16'h5, 16'(sink.sink_on));
		rdchk(8'h71, 8'h00, 1'b0);
		$display("modes done");
	endtask : t_modes
	task automatic t_codes;
		int sr[4] = '{50, 100, 125, 250};
		for (int c = 0; c < 16; c += 5)
		begin
			host.wr(8'h72, 8'(c));
			host.wr(8'h73, 8'(c));
			chk("conv3_mv", 16'(2900 + 50 * c), 16'(pwr.conv3_mv));
			chk("conv4_mv", 16'(3000 + 50 * c), 16'(pwr.conv4_mv));
		end
		for (int c = 0; c < 8; c++)
		begin
			host.wr(8'h75, {2'h0, 3'(c), 3'(7 - c)});
			host.wr(8'h76, 8'(c));
			chk("sink1_ma", 16'(3 * (c + 1)), 16'(ma1));
			chk("sink2_ma", 16'(3 * (8 - c)), 16'(ma2));
			chk("sink3_ma", 16'(3 * (c + 1)), 16'(ma3));
			if (c < 4) host.wr(8'h77, 8'(c));
			if (c < 4) chk("slew", 16'(sr[c]), 16'(slew));
		end
		$display("codes done");
	endtask : t_codes
	task automatic t_dis;
		host.wr(8'h78, 8'h0F);
		chk("conv_dis", 16'hF, 16'(pwr.conv_discharge_en));
		chk("red_conv_dis", 16'h3, 16'(pwr_r.conv_discharge_en));
		host.wr(8'h78, 8'h08);
		chk("conv_dis", 16'h1, 16'(pwr.conv_discharge_en));
		host.wr(8'h79, 8'h80);
		chk("lin_dis", 16'h001, 16'(pwr.linreg_discharge_en));
		host.wr(8'h7A, 8'h01);
		chk("lin_dis", 16'h101, 16'(pwr.linreg_discharge_en));
		@(posedge clk) srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rdchk(8'h78, 8'h04, 1'b1);
		rdchk(8'h7A, 8'h00, 1'b1);
		$display("discharge done");
	endtask : t_dis
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			finish_test();
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_modes();
		t_codes();
		t_dis();
		finish_test();
	end
endmodule : testbench
bind pocr_bank pocr_monitor #(.HAS_CONV34(HAS_CONV34)) mon (.i_clk(i_clk), .i_srst(i_srst), .i_wr_en(i_wr_en),
	.i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_hit(o_rd_hit), .o_sink(o_sink),
	.o_power(o_power), .o_sink1_ma(o_sink1_ma), .o_sink2_ma(o_sink2_ma), .o_sink3_ma(o_sink3_ma),
	.o_slew_tenth_mv_us(o_slew_tenth_mv_us));
`default_nettype wire
